// ==== pkg/adc_cfg_regs.svh ====
// Register offsets, field positions, reset values and timing figures of the mode port.
// Assumes it is included by its bare name wherever the numbers are needed.
`ifndef ADC_CFG_REGS_SVH
`define ADC_CFG_REGS_SVH

// Serial command word
`define CMD_BITS            5'd16
`define CMD_HDR_BITS        5'd8
`define CMD_LAST_INDEX      5'd15

// Register addresses
`define ADDR_SOFT_RESET     7'h00
`define ADDR_POWER_DOWN     7'h01
`define ADDR_TIMING         7'h02
`define ADDR_OUTPUT_MODE    7'h03
`define ADDR_DATA_FORMAT    7'h04
`define REG_RESET_VALUE     8'h00

// Field positions
`define SOFT_RESET_BIT      7
`define PWR_NAP_CODE        2'h1
`define PWR_SLEEP_BIT       1
`define DCS_BIT             0
`define CLK_INVERT_BIT      3
`define OUTMODE_LO          0
`define OUTMODE_HI          1
`define OUTOFF_BIT          2
`define TERM_ON_BIT         3
`define ILVDS_LO            4
`define ILVDS_HI            6
`define FMT_TWOS_BIT        0
`define FMT_RAND_BIT        1
`define FMT_ALTPOL_BIT      2
`define FMT_TP_EN_BIT       3
`define FMT_TP_LO           4
`define FMT_TP_HI           5

// Output codes
`define OUTMODE_CMOS_FULL   2'h0
`define OUTMODE_LVDS_DDR    2'h2
`define ILVDS_3P5MA         3'h0
`define ALT_POLARITY_MASK   14'h2AAA
`define CHECKER_DATA        14'h1555
`define CHECKER_OVERRANGE   1'h1

// Timing
`define SYS_CLK_MHZ         100
`define SLEEP_WAKE_MS       2
`define NAP_WAKE_CYCLES     100
`define NAP_SETTLE_US       50

`endif

// ==== pkg/adc_cfg_pkg.sv ====
// Types shared by the mode port, its serial shifter and its sample formatter.
// Assumes the constants header is available on the include path.
package adc_cfg_pkg;

	typedef struct packed {
		logic       readFlag;
		logic [6:0] regAddr;
		logic [7:0] regData;
	} cmd_t;

	typedef struct packed {
		logic [7:0] powerDown;
		logic [7:0] timing;
		logic [7:0] outputMode;
		logic [7:0] dataFormat;
	} mode_cfg_t;

	typedef enum logic [1:0] {
		PAT_ALL_ZEROS   = 2'b00,
		PAT_ALL_ONES    = 2'b01,
		PAT_ALTERNATING = 2'b10,
		PAT_CHECKER     = 2'b11
	} pattern_t;

	typedef enum logic [1:0] {
		PWR_ACTIVE = 2'b00,
		PWR_SLEEP  = 2'b01,
		PWR_NAP    = 2'b10,
		PWR_WAKING = 2'b11
	} power_state_t;

endpackage : adc_cfg_pkg

// ==== rtl/serial_cmd_shifter.sv ====
// Serial command shifter on the serial clock, framed by chip select.
// Assumes the chip select pin is quiet while the serial clock runs in parallel mode.
`timescale 1ns/10ps
`include "adc_cfg_regs.svh"

module serial_cmd_shifter (
	input  wire logic        sclk,
	input  wire logic        rst_n,
	input  wire logic        csPin_n,
	input  wire logic        sdiPin,
	input  wire logic [7:0]  readData,
	output logic [6:0]       peekAddr,
	output logic             wordDone,
	output adc_cfg_pkg::cmd_t nextWord,
	output logic             sdoPull
);

	logic        frame_n;
	logic [4:0]  bitCount;
	logic [14:0] shift;
	logic        readActive;
	logic [7:0]  readByte;

	// Chip select high ends the frame at once; a clock that stops needs no last edge
	assign frame_n  = rst_n & ~csPin_n;
	assign peekAddr = {shift[5:0], sdiPin};
	assign wordDone = (bitCount == `CMD_LAST_INDEX);
	assign nextWord = adc_cfg_pkg::cmd_t'({shift, sdiPin});

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge sclk or negedge frame_n) begin
		if (!frame_n) begin
			bitCount <= 5'h00;
			shift    <= 15'h0000;
		end else if (bitCount != `CMD_BITS) begin
			bitCount <= bitCount + 5'h01;
			shift    <= {shift[13:0], sdiPin};
		end
	end

	always_ff @(posedge sclk or negedge frame_n) begin
		if (!frame_n) begin
			readActive <= 1'b0;
			readByte   <= 8'h00;
		end else if (bitCount == (`CMD_HDR_BITS - 5'h01)) begin
			readActive <= shift[6];
			readByte   <= readData;
		end
	end

	// Launch on falling edges so each bit is settled at the next rising edge
	always_ff @(negedge sclk or negedge frame_n) begin
		if (!frame_n) begin
			sdoPull <= 1'b0;
		end else if (readActive && bitCount >= `CMD_HDR_BITS && bitCount < `CMD_BITS) begin
			sdoPull <= ~readByte[3'(`CMD_LAST_INDEX - bitCount)];
		end else begin
			sdoPull <= 1'b0;
		end
	end

endmodule : serial_cmd_shifter

// ==== rtl/sample_formatter.sv ====
// Output formatting and test patterns for the converter's sample words.
// Assumes one valid strobe per sample on the system clock.
`timescale 1ns/10ps
`include "adc_cfg_regs.svh"

module sample_formatter (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [13:0] sampleIn,
	input  wire logic        overrangeIn,
	input  wire logic        sampleValid,
	input  wire logic [7:0]  dataFormat,
	output logic [13:0]      sampleBits,
	output logic             overrangeFlag
);

	logic patternPhase;

	function automatic logic [13:0] encode(input logic [13:0] raw, input logic [7:0] fmt);
		logic [13:0] d;
		d = raw;
		// Alternate polarity forces offset binary
		if (fmt[`FMT_TWOS_BIT] && !fmt[`FMT_ALTPOL_BIT]) begin
			d[13] = ~d[13];
		end
		if (fmt[`FMT_RAND_BIT]) begin
			d[13:1] = d[13:1] ^ {13{d[0]}};
		end
		if (fmt[`FMT_ALTPOL_BIT]) begin
			d = d ^ `ALT_POLARITY_MASK;
		end
		return d;
	endfunction : encode

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			patternPhase <= 1'b0;
		end else if (sampleValid) begin
			patternPhase <= ~patternPhase;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sampleBits    <= 14'h0000;
			overrangeFlag <= 1'b0;
		end else if (sampleValid) begin
			if (dataFormat[`FMT_TP_EN_BIT]) begin
				unique case (adc_cfg_pkg::pattern_t'(dataFormat[`FMT_TP_HI:`FMT_TP_LO]))
					adc_cfg_pkg::PAT_ALL_ZEROS: begin
						{overrangeFlag, sampleBits} <= 15'h0000;
					end
					adc_cfg_pkg::PAT_ALL_ONES: begin
						{overrangeFlag, sampleBits} <= 15'h7FFF;
					end
					adc_cfg_pkg::PAT_ALTERNATING: begin
						{overrangeFlag, sampleBits} <= {15{~patternPhase}};
					end
					adc_cfg_pkg::PAT_CHECKER: begin
						overrangeFlag <= `CHECKER_OVERRANGE ^ patternPhase;
						sampleBits    <= `CHECKER_DATA ^ {14{patternPhase}};
					end
				endcase
			end else begin
				sampleBits    <= encode(sampleIn, dataFormat);
				overrangeFlag <= overrangeIn;
			end
		end
	end

endmodule : sample_formatter

// ==== rtl/adc_mode_config_port.sv ====
// Mode-control port of a 14-bit sampling converter: serial register port,
// parallel strap decode, power modes, output disable and test patterns.
// Assumes the converter core samples on sys_clk and strobes each sample;
// the serial clock is the link clock and only runs inside chip-select frames.
`timescale 1ns/10ps
`include "adc_cfg_regs.svh"

module adc_mode_config_port #(
	parameter int SLEEP_WAKE_CYCLES = `SLEEP_WAKE_MS * `SYS_CLK_MHZ * 1000
) (
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	input  wire logic        sclk,
	input  wire logic        programModeSelect,
	input  wire logic        csPin_n,
	input  wire logic        sdiPin,
	output logic             sdoOut,
	output logic             sdoOe,
	input  wire logic [13:0] coreSample,
	input  wire logic        coreOverrange,
	input  wire logic        coreSampleValid,
	output logic [13:0]      sampleBits,
	output logic             sampleBitsOe,
	output logic             overrangeFlag,
	output logic             overrangeFlagOe,
	output logic             outputDataClock,
	output logic             outputDataClockOe,
	output logic             dutyStabilizerOn,
	output logic [1:0]       outputModeSel,
	output logic [2:0]       lvdsCurrentSel,
	output logic             internalTermOn,
	output logic [1:0]       clockPhaseSel,
	output logic             sleepMode,
	output logic             napMode,
	output logic             conversionReady
);

	localparam logic [17:0] SLEEP_WAKE = 18'(SLEEP_WAKE_CYCLES - 1);
	localparam logic [17:0] NAP_WAKE   = 18'(`NAP_WAKE_CYCLES - 1);

	// Reset and pin synchronisers
	logic                         rstMeta;
	logic                         rst_n;
	logic [3:0]                   pinMeta;
	logic [3:0]                   pinSync;
	logic                         parallelMode;
	logic                         csLevel;
	logic                         sckLevel;
	logic                         sdiLevel;

	// Link domain
	adc_cfg_pkg::mode_cfg_t       linkCfg;
	adc_cfg_pkg::cmd_t            nextWord;
	logic [6:0]                   peekAddr;
	logic                         wordDone;
	logic [7:0]                   readData;
	logic                         sdoPull;
	logic                         cfgToggle;

	// System domain
	logic                         tglMeta;
	logic                         tglSync;
	logic                         tglSeen;
	adc_cfg_pkg::mode_cfg_t       sysCfg;
	logic [7:0]                   activeFormat;
	logic                         sleepReq;
	logic                         napReq;
	logic                         outOff;
	adc_cfg_pkg::power_state_t    powerState;
	adc_cfg_pkg::power_state_t    next_powerState;
	logic [17:0]                  wakeCount;

	function automatic logic [7:0] readReg(input adc_cfg_pkg::mode_cfg_t cfg,
		input logic [6:0] addr);
		unique case (addr)
			`ADDR_POWER_DOWN:  readReg = cfg.powerDown;
			`ADDR_TIMING:      readReg = cfg.timing;
			`ADDR_OUTPUT_MODE: readReg = cfg.outputMode;
			`ADDR_DATA_FORMAT: readReg = cfg.dataFormat;
			default:           readReg = `REG_RESET_VALUE;
		endcase
	endfunction : readReg

	////////////////////////////////////////////////////////////////////////////
	// Reset release

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rstMeta <= 1'b0;
			rst_n   <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rst_n   <= rstMeta;
		end
	end

	// Pins used as static straps in parallel mode
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pinMeta <= 4'h0;
			pinSync <= 4'h0;
		end else begin
			pinMeta <= {programModeSelect, csPin_n, sclk, sdiPin};
			pinSync <= pinMeta;
		end
	end

	assign parallelMode = pinSync[3];
	assign csLevel      = pinSync[2];
	assign sckLevel     = pinSync[1];
	assign sdiLevel     = pinSync[0];

	////////////////////////////////////////////////////////////////////////////
	// Serial register port, link clock domain

	serial_cmd_shifter u_shifter (
		.sclk     (sclk),
		.rst_n    (rst_n),
		.csPin_n  (csPin_n),
		.sdiPin   (sdiPin),
		.readData (readData),
		.peekAddr (peekAddr),
		.wordDone (wordDone),
		.nextWord (nextWord),
		.sdoPull  (sdoPull)
	);

	assign readData = readReg(linkCfg, peekAddr);

	// Registers change only on the sixteenth edge, so a short frame leaves them alone
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			linkCfg   <= '0;
			cfgToggle <= 1'b0;
		end else if (wordDone && !csPin_n && !nextWord.readFlag) begin
			cfgToggle <= ~cfgToggle;
			unique case (nextWord.regAddr)
				`ADDR_SOFT_RESET: begin
					// The reset bit is never stored, so it reads back as zero
					if (nextWord.regData[`SOFT_RESET_BIT]) begin
						linkCfg <= '0;
					end
				end
				`ADDR_POWER_DOWN: begin
					linkCfg.powerDown <= nextWord.regData;
				end
				`ADDR_TIMING: begin
					linkCfg.timing <= nextWord.regData;
				end
				`ADDR_OUTPUT_MODE: begin
					linkCfg.outputMode <= nextWord.regData;
				end
				`ADDR_DATA_FORMAT: begin
					linkCfg.dataFormat <= nextWord.regData;
				end
				default: begin
					linkCfg <= linkCfg;
				end
			endcase
		end
	end

	// Open-drain answer: the enable carries the zeros, the pad drives low only
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sdoOut <= 1'b0;
		end else begin
			sdoOut <= 1'b0;
		end
	end

	assign sdoOe = sdoPull;

	////////////////////////////////////////////////////////////////////////////
	// Configuration crossing into the system domain

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tglMeta <= 1'b0;
			tglSync <= 1'b0;
			tglSeen <= 1'b0;
		end else begin
			tglMeta <= cfgToggle;
			tglSync <= tglMeta;
			tglSeen <= tglSync;
		end
	end

	// Words stay still for fifteen serial clocks after each toggle, ample to copy
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sysCfg <= '0;
		end else if (tglSync != tglSeen) begin
			sysCfg <= linkCfg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Effective mode selection

	always_comb begin
		if (parallelMode) begin
			sleepReq     = sdiLevel;
			napReq       = 1'b0;
			outOff       = 1'b0;
			activeFormat = `REG_RESET_VALUE;
		end else begin
			sleepReq     = sysCfg.powerDown[`PWR_SLEEP_BIT];
			napReq       = !sysCfg.powerDown[`PWR_SLEEP_BIT]
				&& sysCfg.powerDown[1:0] == `PWR_NAP_CODE;
			outOff       = sysCfg.outputMode[`OUTOFF_BIT];
			activeFormat = sysCfg.dataFormat;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dutyStabilizerOn <= 1'b0;
			outputModeSel    <= `OUTMODE_CMOS_FULL;
			lvdsCurrentSel   <= `ILVDS_3P5MA;
			internalTermOn   <= 1'b0;
			clockPhaseSel    <= 2'h0;
		end else if (parallelMode) begin
			dutyStabilizerOn <= csLevel;
			outputModeSel    <= sckLevel ? `OUTMODE_LVDS_DDR : `OUTMODE_CMOS_FULL;
			lvdsCurrentSel   <= `ILVDS_3P5MA;
			internalTermOn   <= 1'b0;
			clockPhaseSel    <= 2'h0;
		end else begin
			dutyStabilizerOn <= sysCfg.timing[`DCS_BIT];
			outputModeSel    <= sysCfg.outputMode[`OUTMODE_HI:`OUTMODE_LO];
			lvdsCurrentSel   <= sysCfg.outputMode[`ILVDS_HI:`ILVDS_LO];
			internalTermOn   <= sysCfg.outputMode[`TERM_ON_BIT];
			clockPhaseSel    <= sysCfg.timing[2:1];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power modes and recovery

	always_comb begin
		next_powerState = powerState;
		unique case (powerState)
			adc_cfg_pkg::PWR_ACTIVE: begin
				if (sleepReq) begin
					next_powerState = adc_cfg_pkg::PWR_SLEEP;
				end else if (napReq) begin
					next_powerState = adc_cfg_pkg::PWR_NAP;
				end
			end
			adc_cfg_pkg::PWR_SLEEP: begin
				if (!sleepReq) begin
					next_powerState = napReq ? adc_cfg_pkg::PWR_NAP : adc_cfg_pkg::PWR_WAKING;
				end
			end
			adc_cfg_pkg::PWR_NAP: begin
				if (sleepReq) begin
					next_powerState = adc_cfg_pkg::PWR_SLEEP;
				end else if (!napReq) begin
					next_powerState = adc_cfg_pkg::PWR_WAKING;
				end
			end
			adc_cfg_pkg::PWR_WAKING: begin
				if (sleepReq) begin
					next_powerState = adc_cfg_pkg::PWR_SLEEP;
				end else if (napReq) begin
					next_powerState = adc_cfg_pkg::PWR_NAP;
				end else if (wakeCount == 18'h00000) begin
					next_powerState = adc_cfg_pkg::PWR_ACTIVE;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			powerState <= adc_cfg_pkg::PWR_ACTIVE;
		end else begin
			powerState <= next_powerState;
		end
	end

	// Recovery time depends on what was powered down
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wakeCount <= 18'h00000;
		end else if (powerState == adc_cfg_pkg::PWR_SLEEP) begin
			wakeCount <= SLEEP_WAKE;
		end else if (powerState == adc_cfg_pkg::PWR_NAP) begin
			wakeCount <= NAP_WAKE;
		end else if (wakeCount != 18'h00000) begin
			wakeCount <= wakeCount - 18'h00001;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sleepMode       <= 1'b0;
			napMode         <= 1'b0;
			conversionReady <= 1'b0;
		end else begin
			sleepMode       <= next_powerState == adc_cfg_pkg::PWR_SLEEP;
			napMode         <= next_powerState == adc_cfg_pkg::PWR_NAP;
			conversionReady <= next_powerState == adc_cfg_pkg::PWR_ACTIVE;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sample outputs

	sample_formatter u_formatter (
		.clk           (sys_clk),
		.rst_n         (rst_n),
		.sampleIn      (coreSample),
		.overrangeIn   (coreOverrange),
		.sampleValid   (coreSampleValid),
		.dataFormat    (activeFormat),
		.sampleBits    (sampleBits),
		.overrangeFlag (overrangeFlag)
	);

	// With CLK_INVERT_BIT clear the clock falls with each data update, so its rising edge latches settled data
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			outputDataClock <= 1'b0;
		end else begin
			outputDataClock <= ~coreSampleValid ^ (!parallelMode && sysCfg.timing[`CLK_INVERT_BIT]);
		end
	end

	// Disable is slow by design; it is not meant for bus sharing at sample rate
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sampleBitsOe      <= 1'b0;
			overrangeFlagOe   <= 1'b0;
			outputDataClockOe <= 1'b0;
		end else begin
			sampleBitsOe      <= !outOff;
			overrangeFlagOe   <= !outOff;
			outputDataClockOe <= !outOff;
		end
	end

endmodule : adc_mode_config_port

// ==== bench/adc_mode_config_port_asserts.sv ====
// Checker for the mode port: power states, straps, enables and serial output.
// Assumes it is bound onto adc_mode_config_port and sees only its ports.
`timescale 1ns/10ps
module adc_mode_config_port_asserts #(
	parameter int SLEEP_WAKE_CYCLES = 50
) (
	input wire logic        sys_clk,
	input wire logic        arst_n,
	input wire logic        programModeSelect,
	input wire logic        csPin_n,
	input wire logic        sclk,
	input wire logic        coreSampleValid,
	input wire logic        sdoOut,
	input wire logic        sdoOe,
	input wire logic [13:0] sampleBits,
	input wire logic        sampleBitsOe,
	input wire logic        overrangeFlagOe,
	input wire logic        outputDataClockOe,
	input wire logic        dutyStabilizerOn,
	input wire logic [1:0]  outputModeSel,
	input wire logic [2:0]  lvdsCurrentSel,
	input wire logic        internalTermOn,
	input wire logic        sleepMode,
	input wire logic        napMode,
	input wire logic        conversionReady
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////////////////////////
	int unsigned wakeCnt;
	logic [1:0]  downKind;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			wakeCnt <= 0;
		else if (sleepMode || napMode || conversionReady)
			wakeCnt <= 0;
		else
			wakeCnt <= wakeCnt + 1;
	end
	// Remembers why the core went down, so each wake-up gets its own bound
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			downKind <= 2'h0;
		else if (napMode)
			downKind <= 2'h2;
		else if (sleepMode)
			downKind <= 2'h1;
		else if (conversionReady)
			downKind <= 2'h0;
	end
	sequence parDcsHigh;
		(programModeSelect && csPin_n)[*8];
	endsequence
	sequence parLvdsStrap;
		(programModeSelect && sclk)[*8];
	endsequence
	////////////////////////////////////////////////////////////
	AST_OE_TOGETHER: assert property (sampleBitsOe == overrangeFlagOe &&
		overrangeFlagOe == outputDataClockOe) else $error("output enables differ");
	AST_SAMPLE_HOLD: assert property (!$past(coreSampleValid) |-> $stable(sampleBits))
		else $error("sample bits moved without a sample");
	AST_MODES_EXCL: assert property (!(sleepMode && napMode))
		else $error("sleep and nap together");
	AST_DOWN_NOT_READY: assert property ((sleepMode || napMode) |-> !conversionReady)
		else $error("ready while powered down");
	AST_NAP_RECOVERY: assert property ($rose(conversionReady) && downKind == 2'h2
		|-> wakeCnt >= 99) else $error("nap recovery too short");
	AST_SLEEP_RECOVERY: assert property ($rose(conversionReady) && downKind == 2'h1
		|-> wakeCnt >= SLEEP_WAKE_CYCLES - 1) else $error("sleep recovery too short");
	AST_PAR_DCS: assert property (parDcsHigh |=> dutyStabilizerOn)
		else $error("stabilizer strap ignored");
	AST_PAR_LVDS: assert property (parLvdsStrap |=> outputModeSel == 2'h2 &&
		lvdsCurrentSel == 3'h0 && !internalTermOn) else $error("output mode strap ignored");
	AST_SDO_IDLE: assert property (csPin_n && $past(csPin_n) |-> !sdoOe)
		else $error("serial output pulled outside frame");
	AST_SDO_OPEN_DRAIN: assert property (sdoOe |-> !sdoOut)
		else $error("serial output driven high");
endmodule : adc_mode_config_port_asserts

bind adc_mode_config_port adc_mode_config_port_asserts #(
	.SLEEP_WAKE_CYCLES(SLEEP_WAKE_CYCLES)
) i_asserts (.sys_clk, .arst_n, .programModeSelect, .csPin_n, .sclk, .coreSampleValid,
	.sdoOut, .sdoOe, .sampleBits, .sampleBitsOe, .overrangeFlagOe, .outputDataClockOe,
	.dutyStabilizerOn, .outputModeSel, .lvdsCurrentSel, .internalTermOn, .sleepMode,
	.napMode, .conversionReady);

// ==== bench/spi_ctrl_model.sv ====
// Configuration controller model: serial frames and parallel straps.
// Assumes an external pull-up folded into sdoLine by the bench.
`timescale 1ns/10ps
module spi_ctrl_model (
	output logic     csPin_n,
	output logic     sclk,
	output logic     sdiPin,
	input wire logic sdoLine
);
	initial begin
		csPin_n = 1'b1;
		sclk = 1'b0;
		sdiPin = 1'b0;
	end
	task automatic strap(input logic c, input logic k, input logic d);
		csPin_n = c;
		sclk = k;
		sdiPin = d;
	endtask : strap
	// Serial clock only runs inside frames; 160 ns period
	task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
		rd = 8'h00;
		csPin_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			sdiPin = (i < 16) ? w[15 - i] : ~sdiPin;
			#80;
			if (i >= 8 && i < 16)
				rd = {rd[6:0], sdoLine};
			sclk = 1'b1;
			#80;
			sclk = 1'b0;
		end
		#80;
		csPin_n = 1'b1;
		sdiPin = ~sdiPin;
		#160;
	endtask : xfer
endmodule : spi_ctrl_model

// ==== bench/tb_adc_mode_config_port.sv ====
// Testbench for the mode port: serial access, power modes, patterns, straps.
// Assumes spi_ctrl_model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module tb_adc_mode_config_port;
	logic        sys_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        programModeSelect = 1'b0;
	logic [13:0] coreSample = 14'h1234;
	logic        coreOverrange = 1'b0;
	logic        coreSampleValid = 1'b0;
	wire logic   sclk, csPin_n, sdiPin, sdoOe, sampleBitsOe, overrangeFlag, overrangeFlagOe;
	wire logic   sdoOut, outputDataClock, outputDataClockOe, dutyStabilizerOn, internalTermOn;
	wire logic   sleepMode, napMode, conversionReady;
	wire logic [13:0] sampleBits;
	wire logic [1:0]  outputModeSel, clockPhaseSel;
	wire logic [2:0]  lvdsCurrentSel;
	int          errorCnt = 0;
	int          nCompared = 0;
	logic [7:0]  d;
	logic [14:0] e0 [4] = '{15'h0000, 15'h7FFF, 15'h7FFF, 15'h5555};
	logic [14:0] e1 [4] = '{15'h0000, 15'h7FFF, 15'h0000, 15'h2AAA};
	initial forever #5 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////
	adc_mode_config_port #(.SLEEP_WAKE_CYCLES(50)) i_dut (.sys_clk, .arst_n, .sclk,
		.programModeSelect, .csPin_n, .sdiPin, .sdoOut, .sdoOe, .coreSample, .coreOverrange,
		.coreSampleValid, .sampleBits, .sampleBitsOe, .overrangeFlag, .overrangeFlagOe,
		.outputDataClock, .outputDataClockOe, .dutyStabilizerOn, .outputModeSel,
		.lvdsCurrentSel, .internalTermOn, .clockPhaseSel, .sleepMode, .napMode,
		.conversionReady);
	// Open drain with pull-up: released line reads high
	spi_ctrl_model i_ctrl (.csPin_n, .sclk, .sdiPin, .sdoLine(sdoOe ? sdoOut : 1'b1));
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		nCompared++;
		if (got !== exp) begin
			errorCnt++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic chkRange(input int got, input int lo, input int hi, input string what);
		nCompared++;
		if (got < lo || got > hi) begin
			errorCnt++;
			$display("wrong value at %0t: %s took %0d cycles", $time, what, got);
		end
	endtask : chkRange
	task automatic wr(input logic [6:0] a, input logic [7:0] v, input int n = 16);
		logic [7:0] x;
		i_ctrl.xfer({1'b0, a, v}, n, x);
		repeat (2) @(negedge sys_clk);
	endtask : wr
	task automatic rd(input logic [6:0] a, output logic [7:0] v);
		i_ctrl.xfer({1'b1, a, 8'hA5}, 16, v);
	endtask : rd
	// Write power register to zero and count cycles from wake start to ready
	task automatic wake(input int lo, input int hi, input string what);
		int n;
		logic [7:0] x;
		n = 0;
		fork
			i_ctrl.xfer({1'b0, 7'h01, 8'h00}, 16, x);
			begin
				while ((sleepMode || napMode) && n < 2000) begin
					@(negedge sys_clk);
					n++;
				end
				n = 0;
				while (!conversionReady && n < 2000) begin
					@(negedge sys_clk);
					n++;
				end
			end
		join
		chkRange(n, lo, hi, what);
	endtask : wake
	task automatic smp();
		@(negedge sys_clk);
		coreSampleValid = 1'b1;
		@(negedge sys_clk);
		coreSampleValid = 1'b0;
		repeat (2) @(negedge sys_clk);
	endtask : smp
	task automatic closeOut();
		$display("comparisons %0d, mismatches %0d", nCompared, errorCnt);
		if (errorCnt == 0 && nCompared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : closeOut
	////////////////////////////////////////////////////////////
	initial begin
		#400000;
		errorCnt++;
		closeOut();
	end
	initial begin
		repeat (12) @(negedge sys_clk);
		arst_n = 1'b1;
		repeat (6) @(negedge sys_clk);
		wr(7'h00, 8'h80);
		rd(7'h00, d);
		chk(d, 8'h00, "reset register read");
		wr(7'h01, 8'h02);
		chk({sleepMode, napMode, conversionReady}, 3'b100, "sleep");
		rd(7'h01, d);
		chk(d, 8'h02, "power readback");
		wake(48, 53, "sleep wake");
		wr(7'h03, 8'h04);
		chk({sampleBitsOe, overrangeFlagOe, outputDataClockOe}, 3'b000, "disable");
		wr(7'h01, 8'h02);
		wr(7'h00, 8'hFF);
		chk({sleepMode, sampleBitsOe}, 2'b01, "soft reset");
		rd(7'h01, d);
		chk(d, 8'h00, "power after soft reset");
		wr(7'h01, 8'h02, 10);
		rd(7'h01, d);
		chk(d, 8'h00, "short frame");
		wr(7'h01, 8'h01, 20);
		chk({sleepMode, napMode, conversionReady}, 3'b010, "nap");
		wake(98, 103, "nap wake");
		#50000;
		wr(7'h55, 8'h3C);
		rd(7'h55, d);
		chk(d, 8'h00, "unmapped read");
		for (int p = 0; p < 4; p++) begin
			wr(7'h04, {2'b00, p[1:0], 4'hF});
			smp();
			chk({overrangeFlag, sampleBits}, e0[p], "pattern first");
			smp();
			chk({overrangeFlag, sampleBits}, e1[p], "pattern second");
		end
		wr(7'h02, 8'h0B);
		rd(7'h02, d);
		chk({d, dutyStabilizerOn, clockPhaseSel, outputDataClock}, 12'h0BA, "timing");
		wr(7'h04, 8'h01);
		smp();
		chk({overrangeFlag, sampleBits}, 15'h3234, "format");
		programModeSelect = 1'b1;
		i_ctrl.strap(1'b1, 1'b1, 1'b0);
		repeat (10) @(negedge sys_clk);
		chk({dutyStabilizerOn, outputModeSel, lvdsCurrentSel, internalTermOn, sleepMode},
			8'hC0, "straps high");
		i_ctrl.strap(1'b0, 1'b0, 1'b1);
		repeat (10) @(negedge sys_clk);
		chk({dutyStabilizerOn, outputModeSel, lvdsCurrentSel, internalTermOn, sleepMode},
			8'h01, "straps low");
		closeOut();
	end
endmodule : tb_adc_mode_config_port
